// ==== core/ddpi_pkg.sv ====
// shared constants and types for the ddr2 pin interface decoder
package ddpi_pkg;
    localparam int ADDR_W = 13;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int AP_BIT = 10;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    localparam int NUM_LANES = 2;
    localparam int CTL_W = 22;
    localparam int DAT_W = 22;
    localparam int DQS_DIS_BIT = 10;
    localparam logic [BANK_W-1:0] SEL_MODE = 2'h0;
    localparam logic [BANK_W-1:0] SEL_EXT_ONE = 2'h1;
    localparam logic [ADDR_W-1:0] EXT_ONE_RST = 13'h0000;
    localparam logic [3:0] BURST_BEATS = 4'h4;
    localparam logic [3:0] CNT_RST = 4'h0;

    typedef enum logic [2:0] {
        CMD_MODE = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ = 3'h5,
        CMD_RSVD = 3'h6,
        CMD_NOP = 3'h7
    } ddpi_cmd_e;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_DRIVE = 1'b1
    } ddpi_rd_e;
endpackage : ddpi_pkg

// ==== core/ddpi_lane_if.sv ====
// byte lane carrier between the decoder and its lane slices
`timescale 1ns/10ps
interface ddpi_lane_if;
    logic [7:0] dq_s;
    logic dqs_s;
    logic dm_s;
    logic rd_en;
    logic wr_en;
    logic rd_beat;
    logic [7:0] rd_byte;
    logic wr_valid;
    logic [7:0] wr_byte;
    logic [7:0] dq_out;
    logic dq_oe;
    logic dqs_out;
    logic dqs_oe;
    modport ctrl (output dq_s, dqs_s, dm_s, rd_en, wr_en, rd_beat, rd_byte,
                  input wr_valid, wr_byte, dq_out, dq_oe, dqs_out, dqs_oe);
    modport lane (input dq_s, dqs_s, dm_s, rd_en, wr_en, rd_beat, rd_byte,
                  output wr_valid, wr_byte, dq_out, dq_oe, dqs_out, dqs_oe);
endinterface : ddpi_lane_if

// ==== core/ddpi_sync.sv ====
// two flop synchroniser for pin inputs
`timescale 1ns/10ps
module ddpi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule : ddpi_sync

// ==== core/ddpi_lane.sv ====
// one byte lane: write capture on strobe edges, read drive with strobe
`timescale 1ns/10ps
module ddpi_lane
    import ddpi_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    ddpi_lane_if.lane lif
);
    logic dqs_prev_q;
    logic wr_valid_q;
    logic [7:0] wr_byte_q;
    logic [7:0] dq_out_q;
    logic dqs_out_q;
    wire edge_w = lif.dqs_s ^ dqs_prev_q;
    // both strobe edges carry data; a masked byte never shows as valid
    wire take_w = edge_w & lif.wr_en & ~lif.dm_s;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dqs_prev_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_byte_q <= 8'h00;
        end else begin
            dqs_prev_q <= lif.dqs_s;
            wr_valid_q <= take_w;
            if (take_w) begin
                wr_byte_q <= lif.dq_s;
            end
        end
    end

    // strobe flips in the same cycle as the data it marks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dq_out_q <= 8'h00;
            dqs_out_q <= 1'b0;
        end else if (!lif.rd_en) begin
            dqs_out_q <= 1'b0;
        end else if (lif.rd_beat) begin
            dq_out_q <= lif.rd_byte;
            dqs_out_q <= ~dqs_out_q;
        end
    end

    assign lif.wr_valid = wr_valid_q;
    assign lif.wr_byte = wr_byte_q;
    assign lif.dq_out = dq_out_q;
    assign lif.dqs_out = dqs_out_q;
    assign lif.dq_oe = lif.rd_en;
    assign lif.dqs_oe = lif.rd_en;

    a_mask_drop: assert property (@(posedge clk) disable iff (!rstn)
        edge_w && lif.dm_s |=> !wr_valid_q)
        else $error("masked byte reported as valid");
endmodule : ddpi_lane

// ==== core/ddpi_top.sv ====
// ddr2 device pin decoder: commands, banks, mode data, strobes, masks
`timescale 1ns/10ps
module ddpi_top
    import ddpi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic termination_enable_in,
    input wire logic [DQ_W-1:0] data_lanes_in,
    output logic [DQ_W-1:0] data_lanes_out,
    output logic [DQ_W-1:0] data_lanes_oe,
    input wire logic lower_byte_strobe_in,
    output logic lower_byte_strobe_out,
    output logic lower_byte_strobe_oe,
    input wire logic lower_byte_strobe_n_in,
    output logic lower_byte_strobe_n_out,
    output logic lower_byte_strobe_n_oe,
    input wire logic upper_byte_strobe_in,
    output logic upper_byte_strobe_out,
    output logic upper_byte_strobe_oe,
    input wire logic upper_byte_strobe_n_in,
    output logic upper_byte_strobe_n_out,
    output logic upper_byte_strobe_n_oe,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    output logic cmd_valid,
    output ddpi_cmd_e cmd_code,
    output logic [BANK_W-1:0] cmd_bank,
    output logic [ROW_W-1:0] row_addr,
    output logic [COL_W-1:0] col_addr,
    output logic autoprecharge_flag,
    output logic mode_reg_load,
    output logic ext_mode_reg_load,
    output logic [ADDR_W-1:0] mode_reg_data,
    output logic [ADDR_W-1:0] ext_mode_reg_one,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic termination_on,
    output logic clocks_active,
    output logic diff_strobe_en,
    output logic rd_beat_req,
    input wire logic [DQ_W-1:0] rd_data,
    output logic [NUM_LANES-1:0] wr_valid,
    output logic [DQ_W-1:0] wr_data
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: control and clock share latency so they stay aligned
    logic [CTL_W-1:0] ctl_s;
    logic [DAT_W-1:0] dat_s;

    ddpi_sync #(.W(CTL_W)) u_sync_ctl (
        .clk(sys_clk),
        .rstn(rstn),
        .d({ck, cke, cs_n, ras_n, cas_n, we_n, termination_enable_in, bank_sel, addr}),
        .q(ctl_s)
    );

    ddpi_sync #(.W(DAT_W)) u_sync_dat (
        .clk(sys_clk),
        .rstn(rstn),
        .d({upper_byte_strobe_n_in, upper_byte_strobe_in, upper_byte_mask,
            lower_byte_strobe_n_in, lower_byte_strobe_in, lower_byte_mask, data_lanes_in}),
        .q(dat_s)
    );

    wire ck_s = ctl_s[21];
    wire cke_s = ctl_s[20];
    wire cs_s = ctl_s[19];
    wire odt_s = ctl_s[15];
    wire [BANK_W-1:0] bank_s = ctl_s[14:13];
    wire [ADDR_W-1:0] addr_s = ctl_s[12:0];

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    logic ck_prev_q;
    wire ck_rise_w = ck_s & ~ck_prev_q;
    wire ck_edge_w = ck_s ^ ck_prev_q;
    wire ddpi_cmd_e cmd_w = ddpi_cmd_e'(ctl_s[18:16]);
    // clock enable low at the edge blocks every command; termination and a running read burst still update
    wire take_w = ck_rise_w & cke_s & ~cs_s;
    wire is_act_w = take_w & (cmd_w == CMD_ACTIVATE);
    wire is_pre_w = take_w & (cmd_w == CMD_PRECHARGE);
    wire is_rd_w = take_w & (cmd_w == CMD_READ);
    wire is_rw_w = is_rd_w | (take_w & (cmd_w == CMD_WRITE));
    wire is_mode_w = take_w & (cmd_w == CMD_MODE);
    wire is_ext_one_w = is_mode_w & (bank_s == SEL_EXT_ONE);
    wire [ROW_W-1:0] row_w = addr_s[ROW_W-1:0];
    wire [COL_W-1:0] col_w = addr_s[COL_W-1:0];
    wire ap_w = addr_s[AP_BIT];
    wire [NUM_BANKS-1:0] bank_hot_w = NUM_BANKS'(1) << bank_s;

    // precharge with bit 10 high closes all banks; auto-precharge closes the target
    logic [NUM_BANKS-1:0] bank_open_q;
    wire [NUM_BANKS-1:0] bank_open_d =
        is_act_w ? (bank_open_q | bank_hot_w) :
        is_pre_w ? (ap_w ? '0 : (bank_open_q & ~bank_hot_w)) :
        (is_rw_w & ap_w) ? (bank_open_q & ~bank_hot_w) : bank_open_q;

    logic cmd_valid_q;
    ddpi_cmd_e cmd_code_q;
    logic [BANK_W-1:0] cmd_bank_q;
    logic [ROW_W-1:0] row_q;
    logic [COL_W-1:0] col_q;
    logic ap_q;
    logic mr_load_q;
    logic emr_load_q;
    logic [ADDR_W-1:0] mr_data_q;
    logic [ADDR_W-1:0] emr1_q;
    logic odt_q;
    logic cke_on_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ck_prev_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            mr_load_q <= 1'b0;
            emr_load_q <= 1'b0;
            bank_open_q <= '0;
        end else begin
            ck_prev_q <= ck_s;
            cmd_valid_q <= take_w;
            mr_load_q <= is_mode_w & (bank_s == SEL_MODE);
            emr_load_q <= is_mode_w & (bank_s != SEL_MODE);
            bank_open_q <= bank_open_d;
        end
    end

    // data fields hold until the next command of their kind
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cmd_code_q <= CMD_NOP;
            cmd_bank_q <= '0;
            row_q <= '0;
            col_q <= '0;
            ap_q <= 1'b0;
            mr_data_q <= '0;
        end else if (take_w) begin
            cmd_code_q <= cmd_w;
            cmd_bank_q <= bank_s;
            if (is_act_w) begin
                row_q <= row_w;
            end
            if (is_rw_w) begin
                col_q <= col_w;
                ap_q <= ap_w;
            end
            if (is_mode_w) begin
                mr_data_q <= addr_s;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            emr1_q <= EXT_ONE_RST;
            odt_q <= 1'b0;
            cke_on_q <= 1'b0;
        end else begin
            if (is_ext_one_w) begin
                emr1_q <= addr_s;
            end
            if (ck_rise_w) begin
                odt_q <= odt_s;
                cke_on_q <= cke_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read burst: one beat per link clock crossing, both directions
    ddpi_rd_e rd_state_q;
    ddpi_rd_e rd_state_d;
    logic [3:0] rd_cnt_q;
    logic [3:0] rd_cnt_d;
    wire rd_drive_w = (rd_state_q == RD_DRIVE);
    wire rd_beat_w = rd_drive_w & ck_edge_w & (rd_cnt_q < BURST_BEATS) & ~is_rd_w;
    wire rd_done_w = rd_drive_w & ck_edge_w & (rd_cnt_q == BURST_BEATS) & ~is_rd_w;

    // a new read restarts the burst; a deselect cannot restart it, but its link edges still advance the beats
    always_comb begin
        rd_state_d = rd_state_q;
        rd_cnt_d = rd_cnt_q;
        case (rd_state_q)
            RD_IDLE: begin
                if (is_rd_w) begin
                    rd_state_d = RD_DRIVE;
                    rd_cnt_d = CNT_RST;
                end
            end
            RD_DRIVE: begin
                if (is_rd_w) begin
                    rd_cnt_d = CNT_RST;
                end else if (rd_done_w) begin
                    rd_state_d = RD_IDLE;
                end else if (rd_beat_w) begin
                    rd_cnt_d = rd_cnt_q + 4'h1;
                end
            end
            default: begin
                rd_state_d = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_state_q <= RD_IDLE;
            rd_cnt_q <= CNT_RST;
        end else begin
            rd_state_q <= rd_state_d;
            rd_cnt_q <= rd_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte lanes
    ddpi_lane_if lane_if [NUM_LANES] ();
    wire diff_w = ~emr1_q[DQS_DIS_BIT];
    // in differential mode a strobe level counts only when its complement disagrees
    wire lo_dqs_w = diff_w ? (dat_s[17] & ~dat_s[18]) : dat_s[17];
    wire up_dqs_w = diff_w ? (dat_s[20] & ~dat_s[21]) : dat_s[20];
    wire [NUM_LANES-1:0] dqs_w = {up_dqs_w, lo_dqs_w};
    wire [NUM_LANES-1:0] dm_w = {dat_s[19], dat_s[16]};

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign lane_if[g].dq_s = dat_s[g*LANE_W +: LANE_W];
        assign lane_if[g].dqs_s = dqs_w[g];
        assign lane_if[g].dm_s = dm_w[g];
        assign lane_if[g].rd_en = rd_drive_w;
        assign lane_if[g].wr_en = ~rd_drive_w;
        assign lane_if[g].rd_beat = rd_beat_w;
        assign lane_if[g].rd_byte = rd_data[g*LANE_W +: LANE_W];
        assign wr_valid[g] = lane_if[g].wr_valid;
        assign wr_data[g*LANE_W +: LANE_W] = lane_if[g].wr_byte;
        assign data_lanes_out[g*LANE_W +: LANE_W] = lane_if[g].dq_out;
        assign data_lanes_oe[g*LANE_W +: LANE_W] = {LANE_W{lane_if[g].dq_oe}};
        ddpi_lane u_lane (
            .clk(sys_clk),
            .rstn(rstn),
            .lif(lane_if[g])
        );
    end

    assign lower_byte_strobe_out = lane_if[0].dqs_out;
    assign lower_byte_strobe_oe = lane_if[0].dqs_oe;
    assign lower_byte_strobe_n_out = ~lane_if[0].dqs_out;
    assign lower_byte_strobe_n_oe = lane_if[0].dqs_oe & diff_w;
    assign upper_byte_strobe_out = lane_if[1].dqs_out;
    assign upper_byte_strobe_oe = lane_if[1].dqs_oe;
    assign upper_byte_strobe_n_out = ~lane_if[1].dqs_out;
    assign upper_byte_strobe_n_oe = lane_if[1].dqs_oe & diff_w;

    assign cmd_valid = cmd_valid_q;
    assign cmd_code = cmd_code_q;
    assign cmd_bank = cmd_bank_q;
    assign row_addr = row_q;
    assign col_addr = col_q;
    assign autoprecharge_flag = ap_q;
    assign mode_reg_load = mr_load_q;
    assign ext_mode_reg_load = emr_load_q;
    assign mode_reg_data = mr_data_q;
    assign ext_mode_reg_one = emr1_q;
    assign bank_open = bank_open_q;
    assign termination_on = odt_q;
    assign clocks_active = cke_on_q;
    assign diff_strobe_en = diff_w;
    assign rd_beat_req = rd_beat_w;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_row_latch: assert property (is_act_w |=> row_q == $past(row_w))
        else $error("row not latched on activate");
    a_mode_full_addr: assert property (is_mode_w |=> mr_data_q == $past(addr_s))
        else $error("mode data lost address 12");
    a_col_and_ap: assert property (is_rw_w |=> col_q == $past(col_w) && ap_q == $past(ap_w))
        else $error("column or autoprecharge wrong");
    a_bank_target: assert property (is_act_w |=>
        bank_open_q == ($past(bank_open_q) | $past(bank_hot_w)))
        else $error("activate touched wrong bank");
    a_termination_follow: assert property (ck_rise_w |=> termination_on == $past(odt_s))
        else $error("termination not following input");
    a_strobe_direction: assert property (rd_drive_w |->
        lower_byte_strobe_oe && upper_byte_strobe_oe && data_lanes_oe == 16'hffff)
        else $error("lanes not driven during read");
    a_strobe_release: assert property (!rd_drive_w |->
        !lower_byte_strobe_oe && !upper_byte_strobe_oe && data_lanes_oe == 16'h0000)
        else $error("lanes driven outside read");
    a_edge_aligned: assert property (rd_beat_w |=>
        lower_byte_strobe_out != $past(lower_byte_strobe_out) && data_lanes_out == $past(rd_data))
        else $error("read strobe not aligned with data");
    a_diff_gate: assert property (!diff_w |->
        !lower_byte_strobe_n_oe && !upper_byte_strobe_n_oe)
        else $error("complement strobe driven in single mode");
    a_deselect_masked: assert property (ck_rise_w && cs_s |=> !cmd_valid_q)
        else $error("command taken while deselected");
    a_cmd_decode: assert property (cmd_valid_q |-> cmd_code_q == $past(cmd_w))
        else $error("command code mismatch");
    a_rise_only: assert property (!ck_rise_w |=> !cmd_valid_q)
        else $error("command outside rising link edge");
    a_cke_gate: assert property (ck_rise_w && !cke_s |=> !cmd_valid_q && !clocks_active)
        else $error("command taken with clock enable low");
    a_deselect_keeps: assert property (ck_rise_w && cs_s |=>
        $stable(bank_open_q) && rd_state_q == $past(rd_state_q))
        else $error("deselect changed bank or burst state");

    c_activate: cover property (is_act_w);
    c_read_burst: cover property (rd_done_w);
    c_write_byte: cover property (wr_valid == 2'h3);
    c_ext_one_load: cover property (is_ext_one_w);
endmodule : ddpi_top

// ==== dv/ddpi_ctl_model.sv ====
// memory controller model: command frames and write beats
`timescale 1ns/10ps
module ddpi_ctl_model
    import ddpi_pkg::*;
(
    input wire logic sys_clk,
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ADDR_W-1:0] addr,
    output logic [BANK_W-1:0] bank_sel,
    output logic termination_enable_in,
    output logic [DQ_W-1:0] dq,
    output logic lstb,
    output logic ustb,
    output logic lower_byte_mask,
    output logic upper_byte_mask
);
    initial begin
        ck = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        addr = 13'h0000;
        bank_sel = 2'h0;
        termination_enable_in = 1'b0;
        dq = 16'h0000;
        {lstb, ustb, lower_byte_mask, upper_byte_mask} = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one frame per command; the link clock stands low between frames
    task automatic cmd(input logic [3:0] c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
        @(negedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        bank_sel = b;
        addr = a;
        repeat (4) @(negedge sys_clk);
        ck = 1'b1;
        repeat (4) @(negedge sys_clk);
        ck = 1'b0;
        @(negedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank_sel = ~b;
        addr = ~a;
    endtask : cmd
    // strobe edge sits mid-eye; strobes only toggle here, so an even
    // number of beats leaves them low, matching the device's idle level
    task automatic wbeat(input logic [DQ_W-1:0] d, input logic [1:0] m);
        @(negedge sys_clk);
        dq = d;
        {upper_byte_mask, lower_byte_mask} = m;
        repeat (2) @(negedge sys_clk);
        lstb = ~lstb;
        ustb = ~ustb;
        repeat (3) @(negedge sys_clk);
        dq = ~d;
        {upper_byte_mask, lower_byte_mask} = ~m;
    endtask : wbeat
    // level pins are only changed from here, so each has one owner
    task automatic set_pins(input logic e, input logic t);
        cke = e;
        termination_enable_in = t;
    endtask : set_pins
endmodule : ddpi_ctl_model

// ==== dv/ddr2_pin_interface_decode_bench.sv ====
// self-checking bench for the ddr2 pin decoder
`timescale 1ns/10ps
module ddr2_pin_interface_decode_bench
    import ddpi_pkg::*;
;
    logic sys_clk, rstn, ck, cke, cs_n, ras_n, cas_n, we_n, termination_enable_in;
    logic [ADDR_W-1:0] addr, mode_reg_data, ext_mode_reg_one;
    logic [BANK_W-1:0] bank_sel, cmd_bank;
    logic [DQ_W-1:0] dq, data_lanes_in, data_lanes_out, data_lanes_oe, rd_data, wr_data;
    logic lstb, ustb, lower_byte_mask, upper_byte_mask, beat_d;
    logic lower_byte_strobe_in, lower_byte_strobe_out, lower_byte_strobe_oe;
    logic lower_byte_strobe_n_in, lower_byte_strobe_n_out, lower_byte_strobe_n_oe;
    logic upper_byte_strobe_in, upper_byte_strobe_out, upper_byte_strobe_oe;
    logic upper_byte_strobe_n_in, upper_byte_strobe_n_out, upper_byte_strobe_n_oe;
    logic cmd_valid, autoprecharge_flag, mode_reg_load, ext_mode_reg_load;
    logic termination_on, clocks_active, diff_strobe_en, rd_beat_req;
    ddpi_cmd_e cmd_code;
    logic [ROW_W-1:0] row_addr;
    logic [COL_W-1:0] col_addr;
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_LANES-1:0] wr_valid;
    logic [DQ_W-1:0] rd_seen [16];
    logic [5:0] st_seen [16];
    int fails, n_tests, n_cmd, n_mr, n_emr, n_wr0, n_wr1, nb;
    ////////////////////////////////////////////////////////////////////////////////
    // wire level: the device wins only while it enables its driver
    assign data_lanes_in = (data_lanes_oe & data_lanes_out) | (~data_lanes_oe & dq);
    assign lower_byte_strobe_in = lower_byte_strobe_oe ? lower_byte_strobe_out : lstb;
    assign lower_byte_strobe_n_in = lower_byte_strobe_n_oe ? lower_byte_strobe_n_out : ~lstb;
    assign upper_byte_strobe_in = upper_byte_strobe_oe ? upper_byte_strobe_out : ustb;
    assign upper_byte_strobe_n_in = upper_byte_strobe_n_oe ? upper_byte_strobe_n_out : ~ustb;
    assign rd_data = {4'hb, nb[3:0], 4'ha, nb[3:0]};
    ddpi_ctl_model ctl (
        .sys_clk, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank_sel,
        .termination_enable_in, .dq, .lstb, .ustb, .lower_byte_mask, .upper_byte_mask
    );
    ddpi_top DUT (
        .sys_clk, .rstn, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank_sel,
        .termination_enable_in, .data_lanes_in, .data_lanes_out, .data_lanes_oe,
        .lower_byte_strobe_in, .lower_byte_strobe_out, .lower_byte_strobe_oe,
        .lower_byte_strobe_n_in, .lower_byte_strobe_n_out, .lower_byte_strobe_n_oe,
        .upper_byte_strobe_in, .upper_byte_strobe_out, .upper_byte_strobe_oe,
        .upper_byte_strobe_n_in, .upper_byte_strobe_n_out, .upper_byte_strobe_n_oe,
        .lower_byte_mask, .upper_byte_mask, .cmd_valid, .cmd_code, .cmd_bank,
        .row_addr, .col_addr, .autoprecharge_flag, .mode_reg_load, .ext_mode_reg_load,
        .mode_reg_data, .ext_mode_reg_one, .bank_open, .termination_on, .clocks_active,
        .diff_strobe_en, .rd_beat_req, .rd_data, .wr_valid, .wr_data
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // pulses are counted mid-cycle, where they have settled
    always @(negedge sys_clk) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (mode_reg_load === 1'b1) n_mr++;
        if (ext_mode_reg_load === 1'b1) n_emr++;
        if (wr_valid[0] === 1'b1) n_wr0++;
        if (wr_valid[1] === 1'b1) n_wr1++;
        if (beat_d === 1'b1) begin
            rd_seen[nb[3:0]] = data_lanes_out;
            st_seen[nb[3:0]] = {lower_byte_strobe_out, upper_byte_strobe_out,
                                lower_byte_strobe_oe, lower_byte_strobe_n_oe,
                                upper_byte_strobe_oe, upper_byte_strobe_n_oe};
            nb++;
        end
        beat_d = rd_beat_req;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic t_codes;
        int n0;
        for (int c = 0; c < 8; c++) begin
            n0 = n_cmd;
            ctl.cmd({1'b0, c[2:0]}, 2'h3, 13'h0000);
            chk("cmd_code", cmd_code, c[2:0]);
            chk("cmd pulses", n_cmd - n0, 1);
        end
        chk("bank_open", bank_open, 4'h8);
    endtask : t_codes
    task automatic t_act_desel;
        int n0;
        ctl.cmd(4'h3, 2'h2, 13'h1abc);
        chk("row_addr", row_addr, 12'habc);
        chk("cmd_bank", cmd_bank, 2'h2);
        chk("bank_open", bank_open, 4'hc);
        n0 = n_cmd;
        ctl.cmd(4'hb, 2'h0, 13'h0123);
        chk("deselect pulses", n_cmd - n0, 0);
        chk("row_addr kept", row_addr, 12'habc);
        chk("bank_open kept", bank_open, 4'hc);
    endtask : t_act_desel
    task automatic t_cke_odt;
        int n0;
        ctl.set_pins(1'b1, 1'b1);
        ctl.cmd(4'h7, 2'h0, 13'h0000);
        chk("termination_on", termination_on, 1'b1);
        ctl.set_pins(1'b0, 1'b0);
        n0 = n_cmd;
        ctl.cmd(4'h3, 2'h0, 13'h0555);
        chk("termination_off", termination_on, 1'b0);
        chk("clocks_active", clocks_active, 1'b0);
        chk("gated pulses", n_cmd - n0, 0);
        chk("bank_open", bank_open, 4'hc);
        ctl.set_pins(1'b1, 1'b0);
        ctl.cmd(4'h7, 2'h0, 13'h0000);
        chk("clocks_active", clocks_active, 1'b1);
    endtask : t_cke_odt
    task automatic t_writes;
        int a;
        int b;
        a = n_wr0;
        b = n_wr1;
        ctl.wbeat(16'h5a3c, 2'h1);
        ctl.wbeat(16'h7e81, 2'h0);
        ctl.wbeat(16'h1122, 2'h2);
        ctl.wbeat(16'hffff, 2'h3);
        repeat (4) @(negedge sys_clk);
        chk("wr_data", wr_data, 16'h7e22);
        chk("lower captures", n_wr0 - a, 2);
        chk("upper captures", n_wr1 - b, 2);
    endtask : t_writes
    // read with auto-precharge; beats follow each link edge
    task automatic t_read(input logic diff, input logic [1:0] b);
        int base;
        logic [3:0] i;
        base = nb;
        ctl.cmd(4'h5, b, 13'h1f5a);
        chk("col_addr", col_addr, 9'h15a);
        chk("autoprecharge_flag", autoprecharge_flag, 1'b1);
        chk("bank closed", bank_open[b], 1'b0);
        ctl.cmd(4'hf, b, 13'h0000);
        repeat (2) ctl.cmd(4'h7, b, 13'h0000);
        chk("beats", nb - base, 4);
        for (int k = 0; k < 4; k++) begin
            i = 4'(base + k);
            chk("read data", rd_seen[i], {4'hb, i, 4'ha, i});
            chk("strobes", st_seen[i], {~k[0], ~k[0], 1'b1, diff, 1'b1, diff});
        end
        chk("lane enables", data_lanes_oe, 16'h0000);
    endtask : t_read
    task automatic t_modes;
        int a;
        int b;
        a = n_mr;
        b = n_emr;
        ctl.cmd(4'h0, 2'h0, 13'h1234);
        chk("mode_reg_data", mode_reg_data, 13'h1234);
        ctl.cmd(4'h0, 2'h1, 13'h0400);
        chk("ext_mode_reg_one", ext_mode_reg_one, 13'h0400);
        chk("diff_strobe_en", diff_strobe_en, 1'b0);
        ctl.cmd(4'h0, 2'h2, 13'h0000);
        chk("ext one kept", ext_mode_reg_one, 13'h0400);
        chk("mode loads", n_mr - a, 1);
        chk("ext loads", n_emr - b, 2);
    endtask : t_modes
    ////////////////////////////////////////////////////////////////////////////////
    // the whole run is a few microseconds; the limit leaves ample margin
    initial begin
        #50000;
        fails++;
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        chk("cmd_code", cmd_code, CMD_NOP);
        chk("diff_strobe_en", diff_strobe_en, 1'b1);
        chk("strobe n idle", {lower_byte_strobe_n_out, upper_byte_strobe_n_out}, 2'h3);
        chk("bank_open", bank_open, 4'h0);
        ctl.set_pins(1'b1, 1'b0);
        t_codes();
        t_act_desel();
        t_cke_odt();
        t_writes();
        t_read(1'b1, 2'h2);
        t_modes();
        t_read(1'b0, 2'h3);
        chk("banks closed", bank_open, 4'h0);
        ctl.cmd(4'h3, 2'h1, 13'h0000);
        chk("bank one open", bank_open, 4'h2);
        ctl.cmd(4'h2, 2'h0, 13'h0400);
        chk("precharge all", bank_open, 4'h0);
        complete_run();
    end
endmodule : ddr2_pin_interface_decode_bench
